// file: fbfm_pkg.sv
/*
  Constants, states and timing for the bus fault manager of a
  fault-tolerant two-wire transceiver.
  Assumes a single 25 MHz clock; times are in microseconds.
*/
package fbfm_pkg;

  // ==========================================================
  // Clock and time-outs
  localparam int CLK_MHZ          = 25;
  localparam int DOM1_TIMEOUT_US  = 2000;
  localparam int HIGH2_TIMEOUT_US = 4000;
  localparam int HBAT_DET_MAX_US  = 8000;
  localparam int RECOVER_US       = 2000;
  localparam int LBAT_TIMEOUT_US  = 2000;
  localparam int DOM1_CYC         = DOM1_TIMEOUT_US * CLK_MHZ;
  localparam int HIGH2_CYC        = HIGH2_TIMEOUT_US * CLK_MHZ;
  localparam int HBAT_DET_MAX_CYC = HBAT_DET_MAX_US * CLK_MHZ;
  localparam int RECOVER_CYC      = RECOVER_US * CLK_MHZ;
  localparam int LBAT_CYC         = LBAT_TIMEOUT_US * CLK_MHZ;
  localparam int TMR_W            = 18;

  // ==========================================================
  // Pulse-difference counting
  localparam int       CNT_W       = 3;
  localparam bit [2:0] PDIFF_LIMIT = 3'h4;
  localparam bit [2:0] REC_PULSES  = 3'h4;
  localparam bit [2:0] CNT_MAX     = 3'h7;
  localparam bit [2:0] CNT_ZERO    = 3'h0;
  localparam bit [2:0] CNT_ONE     = 3'h1;

  // ==========================================================
  // Comparator input bit positions
  localparam int CMP_N     = 6;
  localparam int CMP_DIFF  = 0;
  localparam int CMP_HIGH  = 1;
  localparam int CMP_LOW   = 2;
  localparam int CMP_HDET  = 3;
  localparam int CMP_LBAT  = 4;
  localparam int CMP_NORM  = 5;

  // ==========================================================
  // Receive path select
  typedef enum logic [1:0] {
    FBFM_RX_DIFF = 2'h0,
    FBFM_RX_HIGH = 2'h1,
    FBFM_RX_LOW  = 2'h2
  } fbfm_rx_t;

  // Gray along normal -> high wait -> high fail; low fail beside
  typedef enum logic [1:0] {
    FBFM_NORMAL    = 2'h0,
    FBFM_HIGH_WAIT = 2'h1,
    FBFM_HIGH_FAIL = 2'h3,
    FBFM_LOW_FAIL  = 2'h2
  } fbfm_state_t;

endpackage : fbfm_pkg

// file: fbfm_fault_manager.sv
/*
  Bus failure manager: edge comparison between the differential and the
  single-ended receivers, time-out detection of shorts, driver and
  termination selection, active-low fault flag.
  Assumes comparator and mode inputs are asynchronous levels from the
  analog front end; outputs steer analog switches directly.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE1] Detector active; failures select configuration
// [RULE2] Benign failures keep full differential configuration
// [RULE3] High short: high driver off, weak pull-down
// [RULE4] Low failures: low driver off, weak pull-up
// [RULE5] Missing single-line edges increment difference counter
// [RULE6] Counter four or more drives fault low
// [RULE7] Four good pulses recover, release fault
// [RULE8] Edge counting only in normal mode
// [RULE9] High supply short detected always, flag held
// [RULE10] First time-out moves to single-wire receive
// [RULE11] Second time-out disables high driver, termination
// [RULE12] Quiet lines for set time recover high
// [RULE13] High termination removed within eight milliseconds
// [RULE14] Above detection threshold, high termination interrupted
// [RULE15] Permanent dominance time-out disables low driver
// [RULE16] Recessive differential for set time recovers low
// [RULE17] Low near battery for time: high-only
// [RULE18] Synchronised inputs, restarting parameterised time-outs
// [RULE19] Counter cleared on recovery and reset
// [RULE20] Reset starts fault-free, fully enabled, flag high
module fbfm_fault_manager #(
  parameter int P_DOM1_CYC   = fbfm_pkg::DOM1_CYC,
  parameter int P_HIGH2_CYC  = fbfm_pkg::HIGH2_CYC,
  parameter int P_DETMAX_CYC = fbfm_pkg::HBAT_DET_MAX_CYC,
  parameter int P_REC_CYC    = fbfm_pkg::RECOVER_CYC,
  parameter int P_LBAT_CYC   = fbfm_pkg::LBAT_CYC
) (
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  input  wire logic               i_diff_dominant,
  input  wire logic               i_high_dominant,
  input  wire logic               i_low_dominant,
  input  wire logic               i_high_above_det,
  input  wire logic               i_low_near_battery,
  input  wire logic               i_normal_mode,
  output var  logic               o_high_drv_en,
  output var  logic               o_low_drv_en,
  output var  logic               o_high_termination,
  output var  logic               o_low_termination,
  output var  fbfm_pkg::fbfm_rx_t o_rx_sel,
  output var  logic               o_bus_fault_flag_alt_n
);
  import fbfm_pkg::*;

  function automatic logic tmr_hit(input logic [TMR_W-1:0] t, input int lim);
    tmr_hit = (t == TMR_W'(lim - 1));
  endfunction : tmr_hit

  // ==========================================================
  // Input synchronisers
  logic [CMP_N-1:0] meta;
  logic [CMP_N-1:0] cmp;
  logic             diff_prev;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta      <= '0;
      cmp       <= '0;
      diff_prev <= 1'b0;
    end else begin
      meta      <= {i_normal_mode, i_low_near_battery, i_high_above_det,
                    i_low_dominant, i_high_dominant, i_diff_dominant}; // see [RULE18]
      cmp       <= meta;
      diff_prev <= cmp[CMP_DIFF];
    end
  end

  wire logic diff_s  = cmp[CMP_DIFF];
  wire logic high_s  = cmp[CMP_HIGH];
  wire logic low_s   = cmp[CMP_LOW];
  wire logic hdet_s  = cmp[CMP_HDET];
  wire logic lbat_s  = cmp[CMP_LBAT];
  wire logic norm_s  = cmp[CMP_NORM];
  wire logic rise    = diff_s & ~diff_prev;
  wire logic fall    = ~diff_s & diff_prev;

  // ==========================================================
  // Pulse-difference counter
  logic             seen_h;
  logic             seen_l;
  logic [CNT_W-1:0] pdiff;
  logic [CNT_W-1:0] good;
  logic             next_seen_h;
  logic             next_seen_l;
  logic [CNT_W-1:0] next_pdiff;
  logic [CNT_W-1:0] next_good;
  fbfm_state_t      state;
  wire logic        eval    = fall & norm_s & (state == FBFM_NORMAL);
  wire logic        both_ok = seen_h & seen_l;
  wire logic        cnt_flt = (pdiff >= PDIFF_LIMIT);

  always_comb begin
    next_seen_h = seen_h | high_s;
    next_seen_l = seen_l | low_s;
    next_pdiff  = pdiff;
    next_good   = good;
    if (rise) begin
      next_seen_h = high_s;
      next_seen_l = low_s;
    end
    if (state != FBFM_NORMAL) begin
      next_pdiff = CNT_ZERO;
      next_good  = CNT_ZERO;
    end else if (eval) begin                                         // see [RULE8]
      if (!both_ok) begin
        next_good = CNT_ZERO;
        if (pdiff != CNT_MAX) begin
          next_pdiff = pdiff + CNT_ONE;                              // see [RULE5]
        end
      end else if (cnt_flt) begin
        if (good == REC_PULSES - CNT_ONE) begin
          next_pdiff = CNT_ZERO;                                     // see [RULE7] [RULE19]
          next_good  = CNT_ZERO;
        end else begin
          next_good = good + CNT_ONE;
        end
      end else begin
        next_good = CNT_ZERO;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      seen_h <= 1'b0;
      seen_l <= 1'b0;
      pdiff  <= CNT_ZERO;                                            // see [RULE19]
      good   <= CNT_ZERO;
    end else begin
      seen_h <= next_seen_h;
      seen_l <= next_seen_l;
      pdiff  <= next_pdiff;
      good   <= next_good;
    end
  end

  // ==========================================================
  // Time-out state machine
  // Timer tmr shared by all states, ltmr for the low-battery time-out; tmr restarts on a state change and whenever the qualifying level drops
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] ltmr;
  fbfm_state_t      next_state;
  logic [TMR_W-1:0] next_tmr;
  logic [TMR_W-1:0] next_ltmr;
  logic             qual;
  logic             hit;
  wire logic        quiet_h = ~diff_s & ~high_s & ~low_s & ~hdet_s;
  wire logic        quiet_l = ~diff_s & ~lbat_s;

  always_comb begin
    next_state = state;
    qual       = 1'b0;
    hit        = 1'b0;
    case (state)
      FBFM_NORMAL: begin
        qual = diff_s;
        hit  = tmr_hit(tmr, P_DOM1_CYC);
        if (qual && hit) begin
          // Supply short lifts the high line; otherwise the low line is at fault
          next_state = hdet_s ? FBFM_HIGH_WAIT : FBFM_LOW_FAIL;     // see [RULE10] [RULE15]
        end else if (lbat_s && tmr_hit(ltmr, P_LBAT_CYC)) begin
          next_state = FBFM_LOW_FAIL;                                // see [RULE17]
        end
      end
      FBFM_HIGH_WAIT: begin
        qual = hdet_s;
        hit  = tmr_hit(tmr, P_HIGH2_CYC);
        if (!hdet_s) begin
          next_state = FBFM_NORMAL;
        end else if (hit) begin
          next_state = FBFM_HIGH_FAIL;                               // see [RULE11] [RULE9]
        end
      end
      FBFM_HIGH_FAIL: begin
        qual = quiet_h;
        hit  = tmr_hit(tmr, P_REC_CYC);
        if (qual && hit) begin
          next_state = FBFM_NORMAL;                                  // see [RULE12]
        end
      end
      FBFM_LOW_FAIL: begin
        qual = quiet_l;
        hit  = tmr_hit(tmr, P_REC_CYC);
        if (qual && hit) begin
          next_state = FBFM_NORMAL;                                  // see [RULE16]
        end
      end
      default: next_state = FBFM_NORMAL;
    endcase
    next_tmr  = (qual && next_state == state) ? tmr + 1'b1 : '0;     // see [RULE18]
    next_ltmr = (lbat_s && state == FBFM_NORMAL) ? ltmr + 1'b1 : '0;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= FBFM_NORMAL;                                          // see [RULE20]
      tmr   <= '0;
      ltmr  <= '0;
    end else begin
      state <= next_state;
      tmr   <= next_tmr;
      ltmr  <= next_ltmr;
    end
  end

  // ==========================================================
  // Driver, termination and receive configuration
  logic     next_hdrv;
  logic     next_ldrv;
  logic     next_hterm;
  logic     next_lterm;
  fbfm_rx_t next_rx;
  logic     next_flag_n;

  always_comb begin
    next_hdrv   = 1'b1;                                              // see [RULE2] [RULE1]
    next_ldrv   = 1'b1;
    next_hterm  = 1'b1;
    next_lterm  = 1'b1;
    next_rx     = FBFM_RX_DIFF;
    next_flag_n = ~(next_pdiff >= PDIFF_LIMIT);                      // see [RULE6]
    case (next_state)
      FBFM_HIGH_WAIT: begin
        next_rx     = FBFM_RX_HIGH;                                  // see [RULE10]
        next_flag_n = 1'b0;
      end
      FBFM_HIGH_FAIL: begin
        // Weak pull-down replaces the resistor, cutting the short current
        next_hdrv   = 1'b0;                                          // see [RULE3] [RULE14]
        next_hterm  = 1'b0;                                          // see [RULE13]
        next_rx     = FBFM_RX_LOW;
        next_flag_n = 1'b0;
      end
      FBFM_LOW_FAIL: begin
        next_ldrv   = 1'b0;                                          // see [RULE4]
        next_lterm  = 1'b0;
        next_rx     = FBFM_RX_HIGH;
        next_flag_n = 1'b0;
      end
      default: next_hdrv = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_high_drv_en          <= 1'b1;                                // see [RULE20]
      o_low_drv_en           <= 1'b1;
      o_high_termination     <= 1'b1;
      o_low_termination      <= 1'b1;
      o_rx_sel               <= FBFM_RX_DIFF;
      o_bus_fault_flag_alt_n <= 1'b1;
    end else begin
      o_high_drv_en          <= next_hdrv;
      o_low_drv_en           <= next_ldrv;
      o_high_termination     <= next_hterm;
      o_low_termination      <= next_lterm;
      o_rx_sel               <= next_rx;
      o_bus_fault_flag_alt_n <= next_flag_n;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_good_last;
    eval && both_ok && cnt_flt && (good == REC_PULSES - CNT_ONE);
  endsequence
  sequence s_released;
    (pdiff == CNT_ZERO) && o_bus_fault_flag_alt_n;
  endsequence

  a_normal_config: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE2]
    state == FBFM_NORMAL |-> o_high_drv_en && o_low_drv_en && o_high_termination
      && o_low_termination && o_rx_sel == FBFM_RX_DIFF)
    else $error("normal state without full configuration");

  a_high_fail_cfg: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE3]
    state == FBFM_HIGH_FAIL |-> !o_high_drv_en && !o_high_termination && o_low_drv_en
      && o_low_termination && o_rx_sel == FBFM_RX_LOW)
    else $error("high failure configuration wrong");

  a_low_fail_cfg: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE4]
    state == FBFM_LOW_FAIL |-> o_high_drv_en && !o_low_drv_en && !o_low_termination
      && o_rx_sel == FBFM_RX_HIGH)
    else $error("low failure configuration wrong");

  a_count_miss: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE5]
    eval && !both_ok && pdiff != CNT_MAX |=> pdiff == $past(pdiff) + CNT_ONE)
    else $error("missing edge not counted");

  a_count_flag: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE6]
    state == FBFM_NORMAL && cnt_flt |-> !o_bus_fault_flag_alt_n && o_high_drv_en
      && o_low_drv_en && o_rx_sel == FBFM_RX_DIFF)
    else $error("counter fault not flagged");

  a_pulse_recover: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE7]
    s_good_last |=> s_released)
    else $error("recovery after good pulses missing");

  a_mode_gate: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE8]
    !norm_s && state == FBFM_NORMAL ##1 state == FBFM_NORMAL |-> $stable(pdiff))
    else $error("edges counted outside normal mode");

  a_fault_held: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE9]
    state != FBFM_NORMAL |-> !o_bus_fault_flag_alt_n)
    else $error("fault flag released during short");

  a_first_step: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE10]
    state == FBFM_NORMAL && diff_s && hdet_s && tmr_hit(tmr, P_DOM1_CYC)
      |=> state == FBFM_HIGH_WAIT && o_rx_sel == FBFM_RX_HIGH)
    else $error("first time-out did not switch receiver");

  a_det_bound: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE13]
    state == FBFM_HIGH_WAIT |-> tmr < TMR_W'(P_DETMAX_CYC - P_DOM1_CYC))
    else $error("high termination not removed in time");

  a_high_recover: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE12]
    state == FBFM_HIGH_FAIL && quiet_h && tmr_hit(tmr, P_REC_CYC)
      |=> state == FBFM_NORMAL ##0 o_bus_fault_flag_alt_n)
    else $error("high short recovery missing");

  a_low_battery: assert property (@(posedge i_clk) disable iff (i_reset) // see [RULE17]
    state == FBFM_NORMAL && !(diff_s && tmr_hit(tmr, P_DOM1_CYC)) && lbat_s
      && tmr_hit(ltmr, P_LBAT_CYC) |=> state == FBFM_LOW_FAIL && !o_low_drv_en)
    else $error("low battery short not handled");

endmodule : fbfm_fault_manager
`default_nettype wire

// file: fbfm_bus_model.sv
/*
  Behavioural model of the other nodes on the two-wire bus, seen
  through this node's comparators, with one injectable bus failure.
  Assumes the bench changes its inputs at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bus as seen by the comparators
// Fault codes: 0 none, 1 high open, 2 low open, 3 high to supply,
// 4 low to ground or lines shorted, 5 low to battery
module fbfm_bus_model (
  input  wire logic       i_tx_dom,
  input  wire logic [2:0] i_fault,
  output var  logic       o_diff_dominant,
  output var  logic       o_high_dominant,
  output var  logic       o_low_dominant,
  output var  logic       o_high_above_det,
  output var  logic       o_low_near_battery
);
  always_comb begin
    o_diff_dominant    = i_tx_dom;
    o_high_dominant    = i_tx_dom;
    o_low_dominant     = i_tx_dom;
    o_high_above_det   = 1'b0;
    o_low_near_battery = 1'b0;
    case (i_fault)
      3'h1: o_high_dominant = 1'b0;
      3'h2: o_low_dominant = 1'b0;
      3'h3: begin
        // Clamped high line looks dominant on the differential and high comparators
        o_diff_dominant  = 1'b1;
        o_high_dominant  = 1'b1;
        o_high_above_det = 1'b1;
      end
      3'h4: begin
        o_diff_dominant = 1'b1;
        o_low_dominant  = 1'b1;
      end
      3'h5: begin
        o_low_dominant     = 1'b0;
        o_low_near_battery = 1'b1;
      end
      default: ;
    endcase
  end
endmodule : fbfm_bus_model

`default_nettype wire

// file: fbfm_fault_manager_bench.sv
/*
  Self-checking bench for the bus fault manager: counter faults, mode
  gating, supply shorts with recovery, time-out restart.
  Assumes the shortened time-out parameters set below.
*/
`timescale 1ns/1ps
`default_nettype none

module fbfm_fault_manager_bench;
  import fbfm_pkg::*;

  // ==========================================================
  // Shortened time-outs and expected configurations
  localparam int DOM1 = 20;
  localparam int HIGH2 = 30;
  localparam int DETMAX = 60;
  localparam int REC = 20;
  localparam int LBAT = 20;
  // {high drv, low drv, high term, low term, rx select, flag}
  localparam logic [6:0] C_NORM  = {4'hF, FBFM_RX_DIFF, 1'b1};
  localparam logic [6:0] C_FLAG  = {4'hF, FBFM_RX_DIFF, 1'b0};
  localparam logic [6:0] C_HWAIT = {4'hF, FBFM_RX_HIGH, 1'b0};
  localparam logic [6:0] C_HFAIL = {4'h5, FBFM_RX_LOW, 1'b0};
  localparam logic [6:0] C_LFAIL = {4'hA, FBFM_RX_HIGH, 1'b0};

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       tx = 1'b0;
  logic       mode = 1'b1;
  logic [2:0] fault = 3'h0;
  logic       diff, hdom, ldom, hdet, lbat;
  logic       hd, ld, ht, lt, flag;
  fbfm_rx_t   rx;
  wire  [6:0] cfg;
  int         fail_count = 0;
  int         n_tests = 0;

  assign cfg = {hd, ld, ht, lt, rx, flag};

  always #20 clk = ~clk;

  fbfm_bus_model fbfm_bus_model_inst (
    .i_tx_dom(tx), .i_fault(fault), .o_diff_dominant(diff),
    .o_high_dominant(hdom), .o_low_dominant(ldom),
    .o_high_above_det(hdet), .o_low_near_battery(lbat)
  );

  fbfm_fault_manager #(
    .P_DOM1_CYC(DOM1), .P_HIGH2_CYC(HIGH2), .P_DETMAX_CYC(DETMAX),
    .P_REC_CYC(REC), .P_LBAT_CYC(LBAT)
  ) fbfm_fault_manager_inst (
    .i_clk(clk), .i_reset(rst), .i_diff_dominant(diff),
    .i_high_dominant(hdom), .i_low_dominant(ldom), .i_high_above_det(hdet),
    .i_low_near_battery(lbat), .i_normal_mode(mode), .o_high_drv_en(hd),
    .o_low_drv_en(ld), .o_high_termination(ht), .o_low_termination(lt),
    .o_rx_sel(rx), .o_bus_fault_flag_alt_n(flag)
  );

  // ==========================================================
  // Shared helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic chk(input logic [6:0] exp);
    n_tests++;
    if (cfg !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, cfg, exp);
    end
  endtask : chk

  // One dominant pulse, then enough quiet for the sync delay
  task automatic pulse(input logic [2:0] f);
    fault = f;
    tx = 1'b1;
    cyc(4);
    tx = 1'b0;
    cyc(6);
  endtask : pulse

  task automatic end_sim();
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // Scenarios
  task automatic t_counter(input logic [2:0] f);
    repeat (3) pulse(f);
    chk(C_NORM);
    pulse(f);
    chk(C_FLAG);
    repeat (3) pulse(3'h0);
    pulse(f);
    repeat (3) pulse(3'h0);
    chk(C_FLAG);
    pulse(3'h0);
    chk(C_NORM);
    repeat (3) pulse(f);
    chk(C_NORM);
    pulse(f);
    chk(C_FLAG);
    repeat (4) pulse(3'h0);
    chk(C_NORM);
  endtask : t_counter

  task automatic t_mode();
    mode = 1'b0;
    repeat (5) pulse(3'h1);
    chk(C_NORM);
    mode = 1'b1;
  endtask : t_mode

  // Run outside normal mode on purpose: detection must not depend on it
  task automatic t_high();
    mode = 1'b0;
    fault = 3'h3;
    cyc(DOM1 - 2);
    chk(C_NORM);
    cyc(6);
    chk(C_HWAIT);
    cyc(HIGH2 - 8);
    chk(C_HWAIT);
    cyc(8);
    chk(C_HFAIL);
    fault = 3'h0;
    cyc(REC - 2);
    chk(C_HFAIL);
    cyc(6);
    chk(C_NORM);
    mode = 1'b1;
  endtask : t_high

  task automatic t_low(input logic [2:0] f, input int lim);
    fault = f;
    cyc(lim - 2);
    chk(C_NORM);
    cyc(6);
    chk(C_LFAIL);
    fault = 3'h0;
    cyc(REC - 2);
    chk(C_LFAIL);
    cyc(6);
    chk(C_NORM);
  endtask : t_low

  // A short quiet gap must restart the dominance time-out
  task automatic t_restart();
    fault = 3'h4;
    cyc(DOM1 - 4);
    fault = 3'h0;
    cyc(3);
    fault = 3'h4;
    cyc(DOM1 - 4);
    chk(C_NORM);
    fault = 3'h0;
    cyc(4);
  endtask : t_restart

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    cyc(19);
    chk(C_NORM);
    cyc(1);
    rst = 1'b0;
    cyc(2);
    chk(C_NORM);
    t_counter(3'h1);
    t_counter(3'h2);
    t_mode();
    t_high();
    t_low(3'h4, DOM1);
    t_low(3'h5, LBAT);
    t_restart();
    end_sim();
  end

  // Whole run is about 700 cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule : fbfm_fault_manager_bench

`default_nettype wire
